// ### logic/hcs_defs.vh
`ifndef HCS_DEFS_VH
`define HCS_DEFS_VH

// Slave address and register offsets
`define HCS_SLAVE_ADDR 7'h2c
`define HCS_GENCALL_ADDR 7'h00
`define HCS_REG_CHARGE 8'hd0
`define HCS_REG_LAST 8'hff
`define HCS_CHG_P1_BIT 1
`define HCS_CHG_P2_BIT 2
`define HCS_RESET_VAL 8'h00
`define HCS_MAX_COUNT 8'h20

// Timing
`define HCS_CLK_HZ 20000000
// 1 us and 2 us counted in 50 ns core clocks
`define HCS_RST_MIN_CYC 6'd20
`define HCS_OUT_MAX_CYC 6'd40
`define HCS_TOUT_MS 25
`define HCS_TOUT_CYC (`HCS_TOUT_MS * (`HCS_CLK_HZ / 1000))

`endif

// ### logic/hcs_sync.v
`timescale 1ns/1ps
`include "hcs_defs.vh"

// Two-stage synchroniser for a group of pin inputs
module hcs_sync #(
    parameter WIDTH = 2,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
    input wire mclk,
    input wire rst_n,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= INIT;
            sync_out <= INIT;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ### logic/hcs_config_slave.v
`timescale 1ns/1ps
`include "hcs_defs.vh"

module hcs_config_slave #(
    parameter TOUT_CYC = `HCS_TOUT_CYC
) (
    input wire mclk,
    input wire rst_n,
    input wire cfg_select,
    input wire port1_charge_strap,
    input wire [1:0] fixed_device_strap,
    input wire smb_clk_in,
    input wire smb_data_in,
    output reg smb_data_out,
    output reg smb_data_oe,
    input wire bus_reset,
    input wire [1:0] over_current,
    input wire [1:0] host_power_on,
    output reg [1:0] port_power_out,
    output reg [1:0] port_enable,
    output reg phy_enable,
    output reg usb_attach,
    output reg self_powered,
    output reg [6:0] dev_address,
    output reg configured,
    output reg suspended,
    output reg tt_clear,
    output reg [1:0] fixed_device
);
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_CMD = 3'd2;
    localparam ST_WCNT = 3'd3;
    localparam ST_WDAT = 3'd4;
    localparam ST_RBYTE = 3'd5;
    localparam ST_IGN = 3'd6;

    wire [6:0] pins_s;
    reg scl_d;
    reg sda_d;
    reg [2:0] state;
    reg [3:0] bitcnt;
    reg [7:0] shreg;
    reg ack_phase;
    reg rd_dir;
    reg cmd_seen;
    reg [7:0] ptr;
    reg [7:0] remain;
    reg [7:0] txbyte;
    reg [7:0] stage [0:31];
    reg [7:0] stage_base;
    reg [5:0] stage_n;
    reg [7:0] wcount;
    reg [7:0] regs [0:255];
    reg [31:0] low_cnt;
    reg [5:0] rst_cnt;
    reg [5:0] out_cnt;
    reg hw_valid;
    reg loaded;
    reg [1:0] oc_latch;
    reg straps_taken;
    reg port1_strap_val;
    reg commit;
    integer i;

    function [7:0] read_reg;
        input [7:0] a;
        begin
            read_reg = regs[a];
        end
    endfunction

    // The SMBus, bus reset, host power and over-current pins go through the same two flip-flops
    hcs_sync #(.WIDTH(7), .INIT(7'b1100000)) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in({smb_clk_in, smb_data_in, bus_reset, host_power_on, over_current}),
        .sync_out(pins_s)
    );

    wire scl = pins_s[6];
    wire sda = pins_s[5];
    wire bus_reset_s = pins_s[4];
    wire [1:0] host_on_s = pins_s[3:2];
    wire [1:0] oc_s = pins_s[1:0];
    wire [7:0] rd_byte = read_reg(ptr);
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire start_c = scl & scl_d & sda_d & ~sda;
    wire stop_c = scl & scl_d & ~sda_d & sda;
    wire [7:0] rx_byte = {shreg[6:0], sda};
    wire [7:0] chg = regs[`HCS_REG_CHARGE];
    // Charge source: strap in default mode, register in SMBus mode
    wire [1:0] chg_en = cfg_select ? {chg[`HCS_CHG_P2_BIT], chg[`HCS_CHG_P1_BIT]}
                                   : {1'b0, port1_strap_val};

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt <= 6'd0;
            hw_valid <= 1'b0;
        end else if (rst_cnt < `HCS_RST_MIN_CYC) begin
            rst_cnt <= rst_cnt + 6'd1;
        end else begin
            hw_valid <= 1'b1;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            straps_taken <= 1'b0;
            port1_strap_val <= 1'b0;
            fixed_device <= 2'b00;
        end else if (!straps_taken) begin
            straps_taken <= 1'b1;
            port1_strap_val <= port1_charge_strap;
            fixed_device <= cfg_select ? 2'b00 : fixed_device_strap;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_cnt <= 6'd0;
        end else if (out_cnt < `HCS_OUT_MAX_CYC) begin
            out_cnt <= out_cnt + 6'd1;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt <= 32'd0;
        end else if (scl || state == ST_IDLE) begin
            low_cnt <= 32'd0;
        end else if (low_cnt < TOUT_CYC) begin
            low_cnt <= low_cnt + 32'd1;
        end
    end
    wire timeout = (low_cnt >= TOUT_CYC);

    // SMBus slave engine; only data line is ever driven
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            state <= ST_IDLE;
            bitcnt <= 4'd0;
            shreg <= 8'h00;
            ack_phase <= 1'b0;
            rd_dir <= 1'b0;
            cmd_seen <= 1'b0;
            ptr <= 8'h00;
            remain <= 8'h00;
            txbyte <= 8'h00;
            stage_base <= 8'h00;
            stage_n <= 6'd0;
            wcount <= 8'h00;
            commit <= 1'b0;
            smb_data_out <= 1'b0;
            smb_data_oe <= 1'b0;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
            commit <= 1'b0;
            if (timeout) begin
                state <= ST_IDLE;
                smb_data_oe <= 1'b0;
                cmd_seen <= 1'b0;
            end else if (stop_c) begin
                // commit only complete, well-formed block writes
                // The STOP's own clock rise has already been counted as one bit
                if (state == ST_WDAT && !ack_phase && bitcnt == 4'd1 && stage_n != 6'd0
                        && {2'b00, stage_n} == wcount) begin
                    commit <= 1'b1;
                end
                // START then STOP also lands here
                state <= ST_IDLE;
                smb_data_oe <= 1'b0;
                cmd_seen <= 1'b0;
            end else if (start_c) begin
                state <= ST_ADDR;
                bitcnt <= 4'd0;
                ack_phase <= 1'b0;
                smb_data_oe <= 1'b0;
            end else if (state != ST_IDLE && state != ST_IGN) begin
                if (scl_rise && !ack_phase && !(state == ST_RBYTE)) begin
                    shreg <= rx_byte;
                    bitcnt <= bitcnt + 4'd1;
                    if (bitcnt == 4'd7) begin
                        ack_phase <= 1'b1;
                        case (state)
                            ST_ADDR: begin
                                if (rx_byte[7:1] != `HCS_SLAVE_ADDR || !cfg_select
                                        || (rx_byte[0] && !cmd_seen)) begin
                                    state <= ST_IGN;
                                    ack_phase <= 1'b0;
                                end
                                rd_dir <= rx_byte[0];
                            end
                            ST_CMD: begin
                                ptr <= rx_byte;
                                stage_base <= rx_byte;
                                cmd_seen <= 1'b1;
                            end
                            ST_WCNT: begin
                                wcount <= rx_byte;
                                remain <= rx_byte;
                                stage_n <= 6'd0;
                                if (rx_byte == 8'h00 || rx_byte > `HCS_MAX_COUNT) begin
                                    state <= ST_IGN;
                                    ack_phase <= 1'b0;
                                end
                            end
                            ST_WDAT: begin
                                if (stage_n < 6'd32) begin
                                    stage[stage_n[4:0]] <= rx_byte;
                                    stage_n <= stage_n + 6'd1;
                                end
                                if (remain == 8'h00) begin
                                    state <= ST_IGN;
                                    ack_phase <= 1'b0;
                                    wcount <= 8'hff;
                                end else begin
                                    remain <= remain - 8'd1;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end else if (scl_rise && state == ST_RBYTE && !ack_phase) begin
                    bitcnt <= bitcnt + 4'd1;
                    if (bitcnt == 4'd7) begin
                        ack_phase <= 1'b1;
                    end
                end else if (scl_rise && ack_phase && state == ST_RBYTE) begin
                    // Master NACK ends the read
                    if (sda) begin
                        state <= ST_IGN;
                    end
                end else if (scl_fall && ack_phase && bitcnt == 4'd8) begin
                    bitcnt <= 4'd0;
                    // Our ACK on writes; on reads let go for the master's ACK
                    smb_data_oe <= (state != ST_RBYTE);
                    smb_data_out <= 1'b0;
                end else if (scl_fall && ack_phase && bitcnt == 4'd0) begin
                    ack_phase <= 1'b0;
                    smb_data_oe <= 1'b0;
                    case (state)
                        ST_ADDR: begin
                            if (rd_dir) begin
                                // First byte out is the count, its top bit is low
                                state <= ST_RBYTE;
                                txbyte <= `HCS_MAX_COUNT;
                                smb_data_oe <= 1'b1;
                                smb_data_out <= 1'b0;
                            end else begin
                                state <= ST_CMD;
                            end
                        end
                        ST_CMD: state <= ST_WCNT;
                        ST_WCNT: state <= ST_WDAT;
                        // next register, pointer steps by one
                        ST_RBYTE: begin
                            txbyte <= rd_byte;
                            ptr <= ptr + 8'd1;
                            smb_data_out <= 1'b0;
                            smb_data_oe <= ~rd_byte[7];
                        end
                        default: begin
                        end
                    endcase
                end else if (scl_fall && state == ST_RBYTE && !ack_phase) begin
                    // Bits 6 to 0; bit 7 went out at the preceding ACK fall
                    smb_data_out <= 1'b0;
                    smb_data_oe <= ~txbyte[3'd7 - bitcnt[2:0]];
                end
            end
        end
    end

    // registers return to defaults; commit path
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 256; i = i + 1) begin
                regs[i] <= `HCS_RESET_VAL;
            end
            loaded <= 1'b0;
        end else if (commit) begin
            for (i = 0; i < 32; i = i + 1) begin
                if (i < stage_n) begin
                    regs[stage_base + i[7:0]] <= stage[i];
                end
            end
            // final status register write completes load
            if (stage_base + {2'b00, stage_n} > {1'b0, `HCS_REG_LAST}) begin
                loaded <= 1'b1;
            end
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            oc_latch <= 2'b00;
            port_power_out <= 2'b00;
        end else begin
            // A new over-current wins over a host re-enable in the same cycle
            oc_latch <= (oc_latch & ~(host_on_s & {2{configured}})) | oc_s;
            port_power_out <= (out_cnt >= `HCS_OUT_MAX_CYC)
                ? ((chg_en | (host_on_s & {2{configured}})) & ~(oc_latch | oc_s))
                : 2'b00;
        end
    end

    // hub-side state; bus reset is never driven downstream
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            port_enable <= 2'b00;
            phy_enable <= 1'b0;
            usb_attach <= 1'b0;
            self_powered <= 1'b0;
            dev_address <= 7'h00;
            configured <= 1'b0;
            suspended <= 1'b0;
            tt_clear <= 1'b0;
        end else begin
            phy_enable <= hw_valid && (out_cnt >= `HCS_OUT_MAX_CYC);
            usb_attach <= hw_valid && (!cfg_select || loaded);
            self_powered <= cfg_select ? regs[8'h06][7] : 1'b1;
            tt_clear <= bus_reset_s;
            if (bus_reset_s) begin
                dev_address <= 7'h00;
                configured <= 1'b0;
                suspended <= 1'b0;
            end
            port_enable <= {2{configured & usb_attach}};
        end
    end
endmodule

// ### testbench/hcs_config_slave_asserts.sv
`timescale 1ns/1ps
module hcs_chk #(
    parameter TOUT_CYC = 2000
) (
    input wire mclk,
    input wire rst_n,
    input wire cfg_select,
    input wire smb_clk_in,
    input wire smb_data_out,
    input wire smb_data_oe,
    input wire bus_reset,
    input wire [1:0] over_current,
    input wire [1:0] port_power_out,
    input wire phy_enable,
    input wire usb_attach,
    input wire self_powered,
    input wire [6:0] dev_address,
    input wire configured,
    input wire suspended
);
    reg [5:0] up_cnt;
    // Saturates so that settled-state checks start well after the power-up delay
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            up_cnt <= 6'h00;
        else if (up_cnt != 6'h3f)
            up_cnt <= up_cnt + 6'h01;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_brst;
        bus_reset [*3];
    endsequence
    sequence s_oc0;
        over_current[0] [*5];
    endsequence
    property p_rel;
        $rose(rst_n) |-> port_power_out == 2'b00 && !phy_enable && !usb_attach;
    endproperty
    a_rel: assert property (p_rel)
        else $error("outputs active at reset release");
    property p_od;
        smb_data_oe |-> !smb_data_out;
    endproperty
    a_od: assert property (p_od)
        else $error("data pin driven high");
    property p_hold;
        smb_clk_in [*3] |-> $stable(smb_data_oe);
    endproperty
    a_hold: assert property (p_hold)
        else $error("data changed while clock high");
    property p_dflt;
        !cfg_select |-> !smb_data_oe;
    endproperty
    a_dflt: assert property (p_dflt)
        else $error("acknowledge in default mode");
    property p_self;
        !cfg_select && up_cnt == 6'h3f |-> self_powered;
    endproperty
    a_self: assert property (p_self)
        else $error("default mode not self-powered");
    property p_brst;
        s_brst |-> dev_address == 7'h00 && !configured && !suspended;
    endproperty
    a_brst: assert property (p_brst)
        else $error("bus reset state wrong");
    property p_keep;
        bus_reset && up_cnt == 6'h3f && over_current == 2'b00 |=> $stable(port_power_out);
    endproperty
    a_keep: assert property (p_keep)
        else $error("port power moved on bus reset");
    property p_oc;
        s_oc0 |-> !port_power_out[0];
    endproperty
    a_oc: assert property (p_oc)
        else $error("power kept under over-current");
endmodule

// ### testbench/hcs_smb_master.sv
`timescale 1ns/1ps
module hcs_smb_master (
    output reg scl,
    output reg sda_low,
    input wire sda
);
    // Clock idles high between frames, data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic clk_bit(input logic b, output logic r);
        sda_low = !b;
        #100;
        scl = 1'b1;
        #100;
        r = sda;
        #100;
        scl = 1'b0;
        #100;
    endtask
    task automatic start_c;
        sda_low = 1'b0;
        #100;
        scl = 1'b1;
        #100;
        sda_low = 1'b1;
        #100;
        scl = 1'b0;
        #100;
    endtask
    task automatic stop_c;
        sda_low = 1'b1;
        #100;
        scl = 1'b1;
        #100;
        sda_low = 1'b0;
        #100;
    endtask
    task automatic start_stop;
        sda_low = 1'b1;
        #100;
        sda_low = 1'b0;
        #100;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            clk_bit(b[i], r);
        clk_bit(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b1, b[i]);
        clk_bit(last, r);
    endtask
endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps
`include "hcs_defs.vh"
module tb;
    typedef struct packed {
        logic [6:0] a;
        logic [7:0] cmd;
        logic [7:0] cnt;
        logic [7:0] d0;
        logic [7:0] d1;
        logic ack;
        logic [1:0] pwr;
    } hcs_row_t;
    reg mclk;
    reg rst_n;
    reg cfg_select;
    reg port1_charge_strap;
    reg bus_reset;
    reg [1:0] over_current;
    wire scl;
    wire m_low;
    wire sda;
    wire smb_data_out;
    wire smb_data_oe;
    wire [1:0] port_power_out;
    wire phy_enable;
    wire usb_attach;
    wire self_powered;
    wire [6:0] dev_address;
    wire configured;
    wire suspended;
    int bad_count;
    int n_compared;
    logic ok;
    logic [7:0] adr_w;
    logic [7:0] rd [0:2];
    hcs_row_t rows [0:6] = '{
        '{7'h2c, 8'hd0, 8'h01, 8'h06, 8'h00, 1'b1, 2'b11},
        '{7'h2c, 8'hcf, 8'h02, 8'h11, 8'h04, 1'b1, 2'b10},
        '{7'h2d, 8'hd0, 8'h01, 8'h06, 8'h00, 1'b0, 2'b10},
        '{7'h00, 8'hd0, 8'h01, 8'h06, 8'h00, 1'b0, 2'b10},
        '{7'h2c, 8'hd0, 8'h00, 8'h06, 8'h00, 1'b0, 2'b10},
        '{7'h2c, 8'hd0, 8'h21, 8'h06, 8'h00, 1'b0, 2'b10},
        '{7'h2c, 8'hd0, 8'h01, 8'h02, 8'h00, 1'b1, 2'b01}};
    // Open-drain data line with pull-up
    assign sda = !(m_low | smb_data_oe);
    hcs_config_slave #(.TOUT_CYC(2000)) u_hcs_config_slave (
        .mclk(mclk), .rst_n(rst_n), .cfg_select(cfg_select),
        .port1_charge_strap(port1_charge_strap), .fixed_device_strap(2'b01),
        .smb_clk_in(scl), .smb_data_in(sda), .smb_data_out(smb_data_out),
        .smb_data_oe(smb_data_oe), .bus_reset(bus_reset), .over_current(over_current),
        .host_power_on(2'b00), .port_power_out(port_power_out), .port_enable(),
        .phy_enable(phy_enable), .usb_attach(usb_attach), .self_powered(self_powered),
        .dev_address(dev_address), .configured(configured), .suspended(suspended),
        .tt_clear(), .fixed_device());
    hcs_smb_master u_hcs_smb_master (.scl(scl), .sda_low(m_low), .sda(sda));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("compared %0d failed %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task blk_wr(input hcs_row_t r, output logic k);
        logic k2;
        @(negedge mclk);
        u_hcs_smb_master.start_c();
        u_hcs_smb_master.wbyte({r.a, 1'b0}, k);
        if (k) u_hcs_smb_master.wbyte(r.cmd, k);
        if (k) u_hcs_smb_master.wbyte(r.cnt, k);
        if (k) u_hcs_smb_master.wbyte(r.d0, k2);
        if (k && r.cnt > 8'h01) u_hcs_smb_master.wbyte(r.d1, k2);
        u_hcs_smb_master.stop_c();
        repeat (10) @(negedge mclk);
    endtask
    task blk_rd(input logic [7:0] cmd);
        @(negedge mclk);
        u_hcs_smb_master.start_c();
        u_hcs_smb_master.wbyte({`HCS_SLAVE_ADDR, 1'b0}, ok);
        u_hcs_smb_master.wbyte(cmd, ok);
        u_hcs_smb_master.start_c();
        u_hcs_smb_master.wbyte({`HCS_SLAVE_ADDR, 1'b1}, ok);
        for (int i = 0; i < 3; i++)
            u_hcs_smb_master.rbyte(i == 2, rd[i]);
        u_hcs_smb_master.stop_c();
        repeat (10) @(negedge mclk);
    endtask
    initial begin
        bad_count = 0;
        n_compared = 0;
        rst_n = 1'b0;
        cfg_select = 1'b0;
        port1_charge_strap = 1'b1;
        bus_reset = 1'b0;
        over_current = 2'b00;
        repeat (20) @(negedge mclk);
        cmp({port_power_out, phy_enable, usb_attach}, 8'h00);
        rst_n = 1'b1;
        repeat (60) @(negedge mclk);
        cmp(port_power_out, 2'b01);
        cmp(self_powered, 1'b1);
        blk_wr(rows[0], ok);
        cmp(ok, 1'b0);
        rst_n = 1'b0;
        cfg_select = 1'b1;
        repeat (20) @(negedge mclk);
        rst_n = 1'b1;
        repeat (60) @(negedge mclk);
        cmp({port_power_out, usb_attach}, 8'h00);
        foreach (rows[i]) begin
            blk_wr(rows[i], ok);
            cmp(ok, rows[i].ack);
            cmp(port_power_out, rows[i].pwr);
        end
        blk_rd(8'hcf);
        cmp(rd[0], `HCS_MAX_COUNT);
        cmp(rd[1], 8'h11);
        cmp(rd[2], 8'h02);
        cmp(usb_attach, 1'b0);
        bus_reset = 1'b1;
        repeat (10) @(negedge mclk);
        cmp({dev_address, configured}, 8'h00);
        cmp(port_power_out, 2'b01);
        bus_reset = 1'b0;
        over_current = 2'b01;
        repeat (10) @(negedge mclk);
        over_current = 2'b00;
        repeat (10) @(negedge mclk);
        cmp(port_power_out, 2'b00);
        // Clock held low past the limit while the slave drives its ACK
        adr_w = {`HCS_SLAVE_ADDR, 1'b0};
        u_hcs_smb_master.start_c();
        for (int i = 7; i >= 0; i--)
            u_hcs_smb_master.clk_bit(adr_w[i], ok);
        repeat (4) @(negedge mclk);
        cmp(smb_data_oe, 1'b1);
        #(2100 * 50);
        cmp(smb_data_oe, 1'b0);
        u_hcs_smb_master.stop_c();
        u_hcs_smb_master.start_stop();
        blk_wr('{7'h2c, 8'hff, 8'h01, 8'h00, 8'h00, 1'b1, 2'b00}, ok);
        cmp(ok, 1'b1);
        cmp(usb_attach, 1'b1);
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge mclk);
        bad_count++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        end_of_test();
    end
endmodule
bind hcs_config_slave hcs_chk #(.TOUT_CYC(TOUT_CYC)) u_hcs_chk (
    .mclk(mclk), .rst_n(rst_n), .cfg_select(cfg_select), .smb_clk_in(smb_clk_in),
    .smb_data_out(smb_data_out), .smb_data_oe(smb_data_oe), .bus_reset(bus_reset),
    .over_current(over_current), .port_power_out(port_power_out),
    .phy_enable(phy_enable), .usb_attach(usb_attach), .self_powered(self_powered),
    .dev_address(dev_address), .configured(configured), .suspended(suspended));
